// ===== design/rio_host.sv
/*
  host controller for one networked remote i/o module with eight inputs and
  eight outputs. software drives it over a simple register port; it sends the
  consumed image to the module and watches the produced image coming back.
  assumes the link below it carries whole images with a valid/ready frame
  handshake and delivers every produced image it hears, tagged with the
  sender's identifier. one clock, synchronous active-low reset.
*/
// The register offsets and strobed register access were left to the implementer.
// Overview of operation
// - comm timeout 400 ms to 25.5 s, default 1000
// - comm-loss flag bit 9, cleared only by host
// - reset flag bit 10, cleared only by host
// - 16-bit status word, unused bits read zero
// - bit 1 set when module does not answer
// - bit 2 set while module awaits configuration
// - bit 3 set on wrong module type
// - bit 4 set on too-old firmware
// - force-send retransmits, then clears itself
// - configured identifier must match module switches
// - identifier valid from 01 to fd
// - link runs at fixed 125 kbaud
module rio_host
  import rio_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = rio_pkg::CYC_PER_MS,  // cycles per ms
  parameter logic [7:0]  EXPECT_CLASS = 8'h5a,  // arbitrary expected class code
  parameter logic [7:0]  MIN_FW       = 8'h01   // oldest firmware accepted
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // software register port
  input  wire logic [2:0]                addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [31:0]               rdata,
  // consumed image toward the module
  output logic                           tx_valid,
  input  wire logic                      tx_ready,
  output logic      [7:0]                tx_node_id,
  output logic      [rio_pkg::CON_BITS-1:0] tx_image,
  output logic                           tx_periodic,
  output logic      [7:0]                tx_interval,
  // produced image from the network
  input  wire logic                      rx_valid,
  input  wire logic [7:0]                rx_node_id,
  input  wire logic [rio_pkg::PRO_BITS-1:0] rx_image
);
  import rio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // identifier inside the usable range
  function automatic logic id_ok(input logic [7:0] id);
    return (id >= NODE_MIN) && (id <= NODE_MAX);
  endfunction

  // keep the timeout inside its legal window
  function automatic logic [15:0] clamp_to(input logic [15:0] v);
    if (v < TIMEOUT_MIN) return TIMEOUT_MIN;
    if (v > TIMEOUT_MAX) return TIMEOUT_MAX;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rio_tx_t                txs;         // transmit sequencer
    logic                   run;         // host running, frames flow
    logic                   pol_neg;     // negative-logic inputs
    logic                   periodic;    // module reports periodically
    logic [7:0]             interval;    // report interval, 100 ms units
    logic [7:0]             node_id;     // module identifier
    logic [7:0]             outs;        // requested output states
    logic [7:0]             hold;        // hold-on-stop mask
    logic [7:0]             ovr;         // override values
    logic [15:0]            timeout;     // comm timeout, ms
    logic                   life_err;    // sticky comm-loss flag
    logic                   pup_err;     // sticky module-reset flag
    logic                   send_now;    // force-send request
    logic                   sn_frame;    // frame in flight serves force-send
    logic                   offline;     // no answer within timeout
    logic                   configured;  // config delivered since module reset
    logic                   seen;        // module answered at least once
    logic                   dirty;       // settings changed, resend
    logic [7:0]             ins;         // input states as reported
    logic                   flt_lo;      // fault, channels 1-4
    logic                   flt_hi;      // fault, channels 5-8
    logic [7:0]             fw;          // reported firmware version
    logic [7:0]             cls;         // reported device class
    logic [15:0]            rx_ms;       // ms since last answer
    logic [15:0]            ref_ms;      // ms since last frame sent
    logic [CON_BITS-1:0]    img;         // frame being offered
    logic [31:0]            rdata;       // read data, one cycle
  } rio_st_t;

  rio_st_t st;
  rio_st_t next_st;

  logic        tick;         // one-ms pulse
  logic [15:0] status_word;  // derived status bits 0-15
  logic        mine;         // frame from our module
  logic        start;        // launch a frame this cycle

  rio_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status word, unused bits stay zero
  always_comb begin
    status_word              = 16'h0000;
    status_word[ST_OFFLINE]  = st.offline;
    status_word[ST_NO_CFG]   = !st.configured;
    status_word[ST_MISMATCH] = st.seen && (st.cls != EXPECT_CLASS);
    status_word[ST_FW_OLD]   = st.seen && (st.fw < MIN_FW);
    status_word[ST_LIFE]     = st.life_err;
    status_word[ST_PUP]      = st.pup_err;
    status_word[ST_NORMAL]   = st.seen && !st.offline && st.configured &&
                               !status_word[ST_MISMATCH] && !status_word[ST_FW_OLD];
  end

  // a produced frame counts only when it carries our identifier; other
  // modules' broadcasts share the wire and are dropped here
  assign mine = rx_valid && (rx_node_id == st.node_id) && id_ok(st.node_id);

  // launch when running at a legal identifier and something needs sending;
  // the refresh at half the timeout keeps the module from falling back
  assign start = (st.txs == RIO_TX_IDLE) && st.run && id_ok(st.node_id) &&
                 (st.dirty || st.send_now || !st.configured ||
                  (st.ref_ms >= {1'b0, st.timeout[15:1]}));

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_st       = st;
    next_st.rdata = 32'h0;

    // ms counters, saturating
    if (tick) begin
      if (st.rx_ms != 16'hffff) next_st.rx_ms = st.rx_ms + 16'h1;
      if (st.ref_ms != 16'hffff) next_st.ref_ms = st.ref_ms + 16'h1;
    end
    // no answer for the timeout: module is offline
    if (st.rx_ms >= st.timeout) next_st.offline = 1'b1;

    // produced frame from our module
    if (mine) begin
      next_st.ins     = rx_image[PRO_IN_LSB +: 8];
      next_st.flt_lo  = rx_image[PRO_FLT_LO];
      next_st.flt_hi  = rx_image[PRO_FLT_HI];
      next_st.fw      = rx_image[PRO_FW_LSB +: 8];
      next_st.cls     = rx_image[PRO_CLS_LSB +: 8];
      next_st.seen    = 1'b1;
      next_st.offline = 1'b0;
      next_st.rx_ms   = 16'h0;
      if (rx_image[PRO_LIFE]) next_st.life_err = 1'b1;
      if (rx_image[PRO_RESET]) begin
        next_st.pup_err    = 1'b1;
        next_st.configured = 1'b0;  // module lost its setup, resend
      end
    end

    // transmit sequencer
    unique case (st.txs)
      RIO_TX_IDLE: begin
        if (start) begin
          // reserved positions go out as zero
          next_st.img                      = '0;
          next_st.img[CON_OUT_LSB +: 8]    = st.outs;
          next_st.img[CON_HOLD_LSB +: 8]   = st.hold;
          next_st.img[CON_POL]             = st.pol_neg;
          next_st.img[CON_OVR_LSB +: 8]    = st.ovr;
          next_st.sn_frame                 = st.send_now;
          next_st.dirty                    = 1'b0;
          next_st.ref_ms                   = 16'h0;
          next_st.txs                      = RIO_TX_BUSY;
        end
      end
      RIO_TX_BUSY: begin
        if (tx_ready) begin
          next_st.txs = RIO_TX_IDLE;
          // a reset report in this cycle wins over the delivery
          if (!(mine && rx_image[PRO_RESET])) next_st.configured = 1'b1;
          if (st.sn_frame) next_st.send_now = 1'b0;
          next_st.sn_frame = 1'b0;
        end
      end
    endcase

    // software writes; placed last so they win, but a fresh report beats a flag clear
    if (wr) begin
      unique case (addr)
        REG_CTRL: begin
          next_st.run      = wdata[CTRL_RUN];
          next_st.pol_neg  = wdata[CTRL_POL];
          next_st.periodic = wdata[CTRL_PERIODIC];
          // interval floor of one unit keeps 100 ms minimum
          next_st.interval = (wdata[CTRL_IVL_LSB +: 8] < IVL_MIN) ?
                             IVL_MIN : wdata[CTRL_IVL_LSB +: 8];
          next_st.dirty    = 1'b1;
        end
        REG_NODE: begin
          next_st.node_id    = wdata[7:0];
          next_st.seen       = 1'b0;
          next_st.configured = 1'b0;
        end
        REG_OUTS: begin
          next_st.outs  = wdata[7:0];
          next_st.dirty = 1'b1;
        end
        REG_HOLD: begin
          next_st.hold  = wdata[7:0];
          next_st.dirty = 1'b1;
        end
        REG_OVR: begin
          next_st.ovr   = wdata[7:0];
          next_st.dirty = 1'b1;
        end
        REG_TIMEOUT: begin
          next_st.timeout = clamp_to(wdata[15:0]);
        end
        REG_STATUS: begin
          // write one clears the sticky flags, a fresh report still wins
          if (wdata[ST_LIFE] && !(mine && rx_image[PRO_LIFE]))
            next_st.life_err = 1'b0;
          if (wdata[ST_PUP] && !(mine && rx_image[PRO_RESET]))
            next_st.pup_err = 1'b0;
          if (wdata[ST_SEND]) next_st.send_now = 1'b1;
        end
        REG_INPUTS: begin
          // read-only view
        end
      endcase
    end

    // software reads, data in the following cycle only
    if (rd) begin
      unique case (addr)
        REG_CTRL:    next_st.rdata = {16'h0, st.interval, 5'h0,
                                      st.periodic, st.pol_neg, st.run};
        REG_NODE:    next_st.rdata = {24'h0, st.node_id};
        REG_OUTS:    next_st.rdata = {24'h0, st.outs};
        REG_HOLD:    next_st.rdata = {24'h0, st.hold};
        REG_OVR:     next_st.rdata = {24'h0, st.ovr};
        REG_TIMEOUT: next_st.rdata = {16'h0, st.timeout};
        REG_STATUS:  next_st.rdata = {15'h0, st.send_now, status_word};
        REG_INPUTS:  next_st.rdata = {st.cls, st.fw, 6'h0,
                                      st.flt_hi, st.flt_lo, st.ins};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st          <= '0;
      st.txs      <= RIO_TX_IDLE;
      st.node_id  <= RST_NODE;
      st.timeout  <= RST_TIMEOUT;
      st.interval <= IVL_MIN;
      st.offline  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the link is assumed to run at LINK_BAUD
  assign rdata       = st.rdata;
  assign tx_valid    = (st.txs == RIO_TX_BUSY);
  assign tx_image    = st.img;
  assign tx_node_id  = st.node_id;
  assign tx_periodic = st.periodic;
  assign tx_interval = st.interval;

endmodule

// ===== design/rio_pkg.sv
/*
  shared constants for the remote i/o host controller: register map,
  field positions, reset values, image layout and timing figures.
  assumes a 25 mhz system clock and word-indexed register access.
*/
package rio_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 40;        // 25 mhz system clock
  localparam int unsigned MS_IN_NS      = 1000000;   // one millisecond
  localparam int unsigned CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
  localparam int unsigned LINK_BAUD     = 125000;    // fixed network rate, no selection

  ////////////////////////////////////////////////////////////////////////////
  // register map (word index on the software port)
  localparam logic [2:0] REG_CTRL     = 3'h0;  // run, polarity, update method
  localparam logic [2:0] REG_NODE     = 3'h1;  // network identifier
  localparam logic [2:0] REG_OUTS     = 3'h2;  // output states
  localparam logic [2:0] REG_HOLD     = 3'h3;  // hold-on-stop mask
  localparam logic [2:0] REG_OVR      = 3'h4;  // override values
  localparam logic [2:0] REG_TIMEOUT  = 3'h5;  // comm timeout, ms
  localparam logic [2:0] REG_STATUS   = 3'h6;  // status word plus force-send
  localparam logic [2:0] REG_INPUTS   = 3'h7;  // produced data view

  // control register fields
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_POL      = 1;
  localparam int CTRL_PERIODIC = 2;
  localparam int CTRL_IVL_LSB  = 8;   // interval in 100 ms units, 8 bits

  // status word bit positions
  localparam int ST_NORMAL  = 0;
  localparam int ST_OFFLINE = 1;
  localparam int ST_NO_CFG  = 2;
  localparam int ST_MISMATCH = 3;
  localparam int ST_FW_OLD  = 4;
  localparam int ST_LIFE    = 9;
  localparam int ST_PUP     = 10;
  localparam int ST_SEND    = 16;

  // reset values
  localparam logic [7:0]  RST_NODE    = 8'h01;
  localparam logic [15:0] RST_TIMEOUT = 16'h03e8;  // 1000 ms
  localparam logic [15:0] TIMEOUT_MIN = 16'h0190;  // 400 ms
  localparam logic [15:0] TIMEOUT_MAX = 16'h639c;  // 25500 ms
  localparam logic [7:0]  IVL_MIN     = 8'h01;     // 100 ms
  localparam logic [7:0]  NODE_MIN    = 8'h01;
  localparam logic [7:0]  NODE_MAX    = 8'hfd;

  ////////////////////////////////////////////////////////////////////////////
  // image layout, image bit n sits at vector index n-1
  localparam int CON_BITS     = 120;
  localparam int PRO_BITS     = 64;
  localparam int CON_OUT_LSB  = 0;    // bits 1-8
  localparam int CON_HOLD_LSB = 64;   // bits 65-72
  localparam int CON_POL      = 79;   // bit 80
  localparam int CON_OVR_LSB  = 96;   // bits 97-104
  localparam int PRO_IN_LSB   = 0;    // bits 1-8
  localparam int PRO_FLT_LO   = 8;    // bit 9
  localparam int PRO_FLT_HI   = 9;    // bit 10
  localparam int PRO_LIFE     = 32;   // status field, comm-loss seen
  localparam int PRO_RESET    = 33;   // status field, module was reset
  localparam int PRO_FW_LSB   = 48;   // bits 49-56
  localparam int PRO_CLS_LSB  = 56;   // bits 57-64

  // transmit sequencer states
  typedef enum logic {RIO_TX_IDLE, RIO_TX_BUSY} rio_tx_t;

endpackage

// ===== design/rio_tick.sv
/*
  millisecond tick generator for the remote i/o host controller.
  assumes one system clock and a synchronous active-low reset.
*/
module rio_tick #(
  parameter int unsigned CYCLES = rio_pkg::CYC_PER_MS  // cycles per tick
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // tick out
  output logic      tick
);
  import rio_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;   // cycles into the current tick
    logic        tick;  // one-cycle pulse
  } rio_tick_st_t;

  rio_tick_st_t st;
  rio_tick_st_t next_st;

  // free-running divider
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(CYCLES - 1)) begin
      next_st.cnt  = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// ===== sim/rio_dev_model.sv
/* behavioural model of the remote i/o module on the far side of the link.
   assumes whole images per frame; timing figures scaled by MS_CYC. */
module rio_dev_model #(
  parameter int unsigned MS_CYC  = 10,    // cycles per scaled millisecond
  parameter int unsigned TMO_CYC = 4000   // module comm timeout in cycles
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // consumed side
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  input  wire logic [7:0]                    tx_node_id,
  input  wire logic [rio_pkg::CON_BITS-1:0]  tx_image,
  input  wire logic                          tx_periodic,
  input  wire logic [7:0]                    tx_interval,
  // produced side
  output logic                               rx_valid,
  output logic [7:0]                         rx_node_id,
  output logic [rio_pkg::PRO_BITS-1:0]       rx_image,
  // bench controls
  input  wire logic [7:0]                    node_sw,   // id switch setting
  input  wire logic [7:0]                    in_pins,   // 1 = pin driven high
  input  wire logic [7:0]                    flt,       // per-channel fault
  input  wire logic [7:0]                    fw,
  input  wire logic [7:0]                    cls,
  input  wire logic                          pup,       // report a module reset
  input  wire logic                          send,      // push one frame
  input  wire logic [4:0]                    slow,      // ready delay
  output logic [7:0]                         out_pins   // physical outputs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  outs, hold, ovr, last_view, view;
  logic        pol, lost, due;
  int unsigned dly, idle, pcnt;
  assign view = in_pins ^ {8{pol}};
  assign due = tx_periodic && pcnt >= tx_interval * 100 * MS_CYC;
  // fail-safe picks hold or override per channel
  assign out_pins = lost ? ((hold & outs) | (~hold & ovr)) : outs;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {outs, hold, ovr, last_view, pol, lost, tx_ready, rx_valid} <= '0;
      {dly, idle, pcnt} <= '0;
      rx_node_id <= 8'h00;
      rx_image <= '0;
    end else begin
      tx_ready <= 1'b0;
      // stall as long as the bench asks
      if (tx_valid && !tx_ready) begin
        dly <= dly + 1;
        if (dly >= slow) tx_ready <= 1'b1;
      end else dly <= 0;
      idle <= idle + 1;
      if (idle >= TMO_CYC) lost <= 1'b1;
      if (tx_valid && tx_ready && tx_node_id == node_sw) begin
        outs <= tx_image[7:0];
        hold <= tx_image[71:64];
        pol <= tx_image[79];
        ovr <= tx_image[103:96];
        idle <= 0;
        lost <= 1'b0;
      end
      pcnt <= pcnt + 1;
      if (send || due || view != last_view) begin
        rx_valid <= 1'b1;
        rx_node_id <= node_sw;
        pcnt <= 0;
        last_view <= view;
        rx_image <= {cls, fw, 14'h0, pup, lost, 22'h0, |flt[7:4], |flt[3:0], view};
      end else begin
        // released lines do not keep their last value
        rx_valid <= 1'b0;
        rx_image <= ~rx_image;
        rx_node_id <= ~rx_node_id;
      end
    end
  end
endmodule

// ===== sim/rio_host_props.sv
/* port-level assertions for the remote i/o host controller.
   assumes a bind onto rio_host and one clock with sync active-low reset. */
module rio_host_props (
  // clock and reset
  input wire logic                          clk_sys,
  input wire logic                          nrst,
  // register port
  input wire logic [2:0]                    addr,
  input wire logic                          rd,
  input wire logic [31:0]                   rdata,
  // link side
  input wire logic                          tx_valid,
  input wire logic                          tx_ready,
  input wire logic [7:0]                    tx_node_id,
  input wire logic [rio_pkg::CON_BITS-1:0]  tx_image,
  input wire logic [7:0]                    tx_interval,
  input wire logic                          rx_valid,
  input wire logic [7:0]                    rx_node_id,
  input wire logic [rio_pkg::PRO_BITS-1:0]  rx_image
);
  timeunit 1ns;
  timeprecision 1ns;
  import rio_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [63:0] last_img;  // last image heard from our own node
  ////////////////////////////////////////////////////////////////////////////
  // mirror of what the inputs view should hold
  always_ff @(posedge clk_sys) begin
    if (!nrst) last_img <= '0;
    else if (rx_valid && rx_node_id == tx_node_id) last_img <= rx_image;
  end
  chk_rd_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside read slot");
  chk_status_pad: assert property (rd && addr == REG_STATUS |=>
    rdata[8:5] == 4'h0 && rdata[15:11] == 5'h0) else $error("status pad bits set");
  chk_tx_steady: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_image) && $stable(tx_node_id)) else $error("frame moved while offered");
  chk_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("no idle cycle after frame");
  chk_tx_reserved: assert property (tx_valid |-> tx_image[63:8] == 56'h0 &&
    tx_image[78:72] == 7'h0 && tx_image[95:80] == 16'h0 && tx_image[119:104] == 16'h0)
    else $error("reserved image bits not zero");
  chk_tx_node: assert property (tx_valid |-> tx_node_id >= NODE_MIN &&
    tx_node_id <= NODE_MAX) else $error("frame sent to invalid id");
  chk_ivl_floor: assert property (tx_interval >= IVL_MIN)
    else $error("update interval below floor");
  chk_inputs_view: assert property (rd && addr == REG_INPUTS && !rx_valid &&
    !$past(rx_valid) |=> rdata == {last_img[63:48], 6'h0, last_img[9:0]})
    else $error("inputs view differs from last frame");
  cov_tx_done: cover property (tx_valid && tx_ready);
  cov_rx_match: cover property (rx_valid && rx_node_id == tx_node_id);
  cov_stall: cover property (tx_valid && !tx_ready [*3]);
endmodule
bind rio_host rio_host_props u_props (.clk_sys, .nrst, .addr, .rd, .rdata, .tx_valid,
  .tx_ready, .tx_node_id, .tx_image, .tx_interval, .rx_valid, .rx_node_id, .rx_image);

// ===== sim/rio_host_tb_top.sv
/* self-checking bench for the remote i/o host controller.
   assumes rio_dev_model on the link and a scaled millisecond tick. */
module rio_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rio_pkg::*;
  localparam int TICK = 10;  // scaled ms keeps the timeouts short
  typedef struct packed {logic [2:0] a; logic [31:0] d; logic [31:0] q;} rio_row_t;
  logic                 clk_sys, nrst, wr, rd, tx_valid, tx_ready, tx_periodic, rx_valid, pup, send;
  logic [2:0]           addr;
  logic [31:0]          wdata, rdata;
  logic [7:0]           tx_node_id, tx_interval, rx_node_id, node_sw, in_pins, flt, fw, cls, out_pins;
  logic [4:0]           slow;
  logic [CON_BITS-1:0]  tx_image, cap;
  logic [PRO_BITS-1:0]  rx_image;
  int                   n_fail, samples_checked;
  rio_row_t rows [9] = '{'{REG_NODE, 32'h5, 32'h5}, '{REG_OUTS, 32'ha5, 32'ha5},
    '{REG_HOLD, 32'h0f, 32'h0f}, '{REG_OVR, 32'h3c, 32'h3c}, '{REG_TIMEOUT, 32'h64, 32'h190},
    '{REG_TIMEOUT, 32'hffff, 32'h639c}, '{REG_TIMEOUT, 32'h190, 32'h190},
    '{REG_CTRL, 32'h4, 32'h104}, '{REG_INPUTS, 32'hffffffff, 32'h0}};
  always #20 clk_sys = ~clk_sys;
  rio_host #(.TICK_CYCLES(TICK)) u_dut (.clk_sys, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .tx_valid, .tx_ready, .tx_node_id, .tx_image, .tx_periodic, .tx_interval,
    .rx_valid, .rx_node_id, .rx_image);
  rio_dev_model #(.MS_CYC(TICK), .TMO_CYC(400 * TICK)) u_dev (.clk_sys, .nrst, .tx_valid,
    .tx_ready, .tx_node_id, .tx_image, .tx_periodic, .tx_interval, .rx_valid, .rx_node_id,
    .rx_image, .node_sw, .in_pins, .flt, .fw, .cls, .pup, .send, .slow, .out_pins);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [2:0] a, logic [31:0] d);
    @(posedge clk_sys); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys); wr <= 1'b0;
  endtask
  task automatic rd_chk(string what, logic [2:0] a, logic [31:0] exp);
    @(posedge clk_sys); rd <= 1'b1; addr <= a;
    @(posedge clk_sys); rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask
  // bounded wait for a frame handshake or a produced frame
  task automatic wait_ev(bit for_rx);
    int i;
    for (i = 0; i < 300; i++) begin
      #1;
      if (for_rx ? rx_valid === 1'b1 : (tx_valid === 1'b1 && tx_ready === 1'b1)) break;
      @(posedge clk_sys);
    end
    if (i == 300) chk("wait", 32'h1, 32'h0);
    cap = tx_image;
    @(posedge clk_sys);
  endtask
  task automatic pulse_send;
    send <= 1'b1;
    @(posedge clk_sys); send <= 1'b0; pup <= 1'b0;
    wait_ev(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_sys, nrst, wr, rd, addr, wdata, in_pins, flt, pup, send, slow} = '0;
    {node_sw, fw, cls, n_fail, samples_checked} = {8'h05, 8'h02, 8'h5a, 64'h0};
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk("node", REG_NODE, 32'h1);
    rd_chk("timeout", REG_TIMEOUT, 32'h3e8);
    rd_chk("status", REG_STATUS, 32'h4);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_chk("row", rows[i].a, rows[i].q);
    end
    chk("method", 32'h101, 32'({tx_periodic, tx_interval}));
    $display("test registers done");
    wr_reg(REG_CTRL, 32'h3);
    wait_ev(0);
    chk("image", 32'h01a50f3c, {7'h0, cap[79], cap[7:0], cap[71:64], cap[103:96]});
    wait_ev(1);
    #1 chk("pins", 32'ha5, 32'(out_pins));
    rd_chk("status", REG_STATUS, 32'h1);
    in_pins <= 8'h81; flt <= 8'h10;
    wait_ev(1);
    rd_chk("inputs", REG_INPUTS, 32'h5a02027e);
    in_pins <= 8'h80; flt <= 8'h01;
    wait_ev(1);
    rd_chk("inputs", REG_INPUTS, 32'h5a02017f);
    $display("test data path done");
    cls <= 8'h33; fw <= 8'h00;
    pulse_send();
    rd_chk("status", REG_STATUS, 32'h18);
    cls <= 8'h5a; fw <= 8'h02; slow <= 5'd20;
    pulse_send();
    wr_reg(REG_STATUS, 32'h10000);
    rd_chk("force", REG_STATUS, 32'h10001);
    wait_ev(0);
    rd_chk("force", REG_STATUS, 32'h1);
    slow <= 5'd0;
    // a frame from another node must leave the inputs view alone
    node_sw <= 8'h06;
    in_pins <= 8'h00;
    wait_ev(1);
    rd_chk("foreign", REG_INPUTS, 32'h5a02017f);
    node_sw <= 8'h05;
    $display("test checks and force done");
    wr_reg(REG_CTRL, 32'h2);
    repeat (4500) @(posedge clk_sys);
    #1 chk("failsafe", 32'h35, 32'(out_pins));
    rd_chk("status", REG_STATUS, 32'h2);
    pup <= 1'b1;
    pulse_send();
    rd_chk("status", REG_STATUS, 32'h604);
    wr_reg(REG_CTRL, 32'h3);
    wait_ev(0);
    rd_chk("status", REG_STATUS, 32'h601);
    wr_reg(REG_STATUS, 32'h200);
    rd_chk("status", REG_STATUS, 32'h401);
    wr_reg(REG_STATUS, 32'h400);
    rd_chk("status", REG_STATUS, 32'h1);
    $display("test loss and recovery done");
    // second reset in mid-run: settings fall back to their reset values
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk("node", REG_NODE, 32'h1);
    rd_chk("timeout", REG_TIMEOUT, 32'h3e8);
    rd_chk("status", REG_STATUS, 32'h4);
    $display("test mid-run reset done");
    report_and_stop();
  end
  initial begin
    repeat (12000) @(posedge clk_sys);
    n_fail++;
    $display("[ERR] watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule
